// ### include/trx_pkg.sv
// Constants, types and helpers for the timer register transfer block.
// Assumes one clock, a synchronous active-high reset and an AXI4-Lite master.
package trx_pkg;

    // ****************************************************************
    // Widths and reset values
    // ****************************************************************
    localparam int          NIB_W    = 4;
    localparam int          BYTE_W   = 8;
    localparam int          ADDR_W   = 8;
    localparam logic [3:0]  RST_NIB  = 4'h0;
    localparam logic [7:0]  RST_BYTE = 8'h00;

    // ****************************************************************
    // Register offsets
    // ****************************************************************
    localparam logic [7:0]  OFF_CMD  = 8'h00;
    localparam logic [7:0]  OFF_ACC  = 8'h04;
    localparam logic [7:0]  OFF_BREG = 8'h08;
    localparam logic [7:0]  OFF_STAT = 8'h0c;
    localparam logic [7:0]  OFF_INTC = 8'h10;
    localparam logic [7:0]  OFF_FSET = 8'h14;
    localparam logic [7:0]  OFF_CTRL = 8'h18;
    localparam logic [7:0]  OFF_PRE  = 8'h1c;
    localparam logic [7:0]  OFF_T1   = 8'h20;
    localparam logic [7:0]  OFF_T2   = 8'h24;
    localparam logic [7:0]  OFF_DISP = 8'h28;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int          EN1_BIT  = 2;
    localparam int          EN2_BIT  = 3;
    localparam int          EN3_BIT  = 0;
    localparam int          CMD_W    = 5;
    localparam int          NFLAG    = 3;

    // ****************************************************************
    // Bus responses
    // ****************************************************************
    localparam logic [1:0]  RESP_OKAY   = 2'b00;
    localparam logic [1:0]  RESP_SLVERR = 2'b10;

    // ****************************************************************
    // Commands
    // ****************************************************************
    typedef enum logic [4:0] {
        CMD_NOP     = 5'h00,
        CMD_MODE_WR = 5'h01,
        CMD_C1_RD   = 5'h02,
        CMD_C1_WR   = 5'h03,
        CMD_C2_RD   = 5'h04,
        CMD_C2_WR   = 5'h05,
        CMD_C3_RD   = 5'h06,
        CMD_C3_WR   = 5'h07,
        CMD_C4_RD   = 5'h08,
        CMD_C4_WR   = 5'h09,
        CMD_PRE_RD  = 5'h0a,
        CMD_PRE_WR  = 5'h0b,
        CMD_T1_RD   = 5'h0c,
        CMD_T1_WR   = 5'h0d,
        CMD_T2_RD   = 5'h0e,
        CMD_T2_WR   = 5'h0f,
        CMD_T2H_WR  = 5'h10,
        CMD_T1R_WR  = 5'h11,
        CMD_T2_LOAD = 5'h12,
        CMD_DISP_WR = 5'h13,
        CMD_TST1    = 5'h14,
        CMD_TST2    = 5'h15,
        CMD_TST3    = 5'h16
    } trx_cmd_t;

    // ****************************************************************
    // Carriers
    // ****************************************************************
    typedef struct packed {
        logic [3:0] fourth;
        logic [3:0] third;
        logic [3:0] second;
        logic [3:0] first;
        logic [3:0] mode;
    } trx_ctrl_t;

    typedef struct packed {
        logic [7:0] pre_cnt;
        logic [7:0] pre_rld;
        logic [7:0] t1_cnt;
        logic [7:0] t1_rld;
        logic [7:0] t2_cnt;
        logic [7:0] t2_rl;
        logic [7:0] t2_rh;
        logic [3:0] disp_cnt;
        logic [3:0] disp_rld;
    } trx_tmr_t;

    // Joins B (high) and accumulator (low) into one byte
    function automatic logic [7:0] trx_join(input logic [3:0] b, input logic [3:0] a);
        return {b, a};
    endfunction

endpackage

// ### rtl/trx_timer_xfer.sv
// Timer register transfer logic with an AXI4-Lite register port.
// Assumes one clock, synchronous reset, and same-clock flag set pulses.
`timescale 1ns/10ps
module trx_timer_xfer
    import trx_pkg::*;
(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rst,
    // Write address channel
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    // Write data channel
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    // Write response channel
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // Read address channel
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    // Read data channel
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // Timer side
    input  wire logic [NFLAG-1:0]  flag_set,
    output trx_ctrl_t              ctrl,
    output logic                   skip_next
);

    // ****************************************************************
    // State
    // ****************************************************************
    logic              awready_q;
    logic              wready_q;
    logic              aw_have_q;
    logic              w_have_q;
    logic [ADDR_W-1:0] awaddr_q;
    logic [31:0]       wdata_q;
    logic              wstrb0_q;
    logic              bvalid_q;
    logic [1:0]        bresp_q;
    logic              arready_q;
    logic              rvalid_q;
    logic [31:0]       rdata_q;
    logic [1:0]        rresp_q;
    logic [3:0]        acc_q;
    logic [3:0]        b_q;
    logic              skip_q;
    logic [3:0]        intc1_q;
    logic [3:0]        intc2_q;
    logic [NFLAG-1:0]  flag_q;
    trx_ctrl_t         ctl_q;
    trx_tmr_t          tm_q;

    logic              wr_fire;
    logic              wr_en;
    logic              cmd_fire;
    trx_cmd_t          cmd;
    logic [NFLAG-1:0]  en_bits;
    logic [NFLAG-1:0]  tst_sel;
    logic [NFLAG-1:0]  flag_clr;
    logic [NFLAG-1:0]  set_all;

    // Offset decode shared by both directions
    function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
        return a == OFF_CMD || a == OFF_ACC || a == OFF_BREG || a == OFF_STAT
            || a == OFF_INTC || a == OFF_FSET || a == OFF_CTRL || a == OFF_PRE
            || a == OFF_T1 || a == OFF_T2 || a == OFF_DISP;
    endfunction

    // ****************************************************************
    // Write channels
    // ****************************************************************
    assign wr_fire  = aw_have_q && w_have_q && !bvalid_q;
    assign wr_en    = wr_fire && wstrb0_q;
    assign cmd_fire = wr_en && awaddr_q == OFF_CMD;
    assign cmd      = trx_cmd_t'(wdata_q[CMD_W-1:0]);

    always_ff @(posedge clk) begin
        if (rst) begin
            awready_q <= 1'b0;
            aw_have_q <= 1'b0;
            awaddr_q  <= '0;
        end else if (awready_q && s_axi_awvalid) begin
            awready_q <= 1'b0;
            aw_have_q <= 1'b1;
            awaddr_q  <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_have_q <= 1'b0;
        end else if (!aw_have_q && !bvalid_q) begin
            awready_q <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wready_q <= 1'b0;
            w_have_q <= 1'b0;
            wdata_q  <= '0;
            wstrb0_q <= 1'b0;
        end else if (wready_q && s_axi_wvalid) begin
            wready_q <= 1'b0;
            w_have_q <= 1'b1;
            wdata_q  <= s_axi_wdata;
            wstrb0_q <= s_axi_wstrb[0];
        end else if (wr_fire) begin
            w_have_q <= 1'b0;
        end else if (!w_have_q && !bvalid_q) begin
            wready_q <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            bvalid_q <= 1'b0;
            bresp_q  <= RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q  <= addr_hit(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // ****************************************************************
    // Read channels
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b0;
            rdata_q   <= '0;
            rresp_q   <= RESP_OKAY;
        end else if (arready_q && s_axi_arvalid) begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b1;
            rresp_q   <= addr_hit(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            unique case (s_axi_araddr)
                OFF_ACC:  rdata_q <= {28'h0000000, acc_q};
                OFF_BREG: rdata_q <= {28'h0000000, b_q};
                OFF_STAT: rdata_q <= {28'h0000000, flag_q, skip_q};
                OFF_INTC: rdata_q <= {24'h000000, intc2_q, intc1_q};
                OFF_FSET: rdata_q <= {29'h00000000, flag_q};
                OFF_CTRL: rdata_q <= {12'h000, ctl_q};
                OFF_PRE:  rdata_q <= {16'h0000, tm_q.pre_rld, tm_q.pre_cnt};
                OFF_T1:   rdata_q <= {16'h0000, tm_q.t1_rld, tm_q.t1_cnt};
                OFF_T2:   rdata_q <= {8'h00, tm_q.t2_rh, tm_q.t2_rl, tm_q.t2_cnt};
                OFF_DISP: rdata_q <= {24'h000000, tm_q.disp_rld, tm_q.disp_cnt};
                default:  rdata_q <= '0;
            endcase
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_q <= 1'b0;
        end else if (!rvalid_q) begin
            arready_q <= 1'b1;
        end
    end

    // ****************************************************************
    // Accumulator and B, bus writes and command results
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            acc_q <= RST_NIB;
            b_q   <= RST_NIB;
        end else if (wr_en && awaddr_q == OFF_ACC) begin
            acc_q <= wdata_q[NIB_W-1:0];
        end else if (wr_en && awaddr_q == OFF_BREG) begin
            b_q <= wdata_q[NIB_W-1:0];
        end else if (cmd_fire) begin
            unique case (cmd)
                CMD_C1_RD: acc_q <= ctl_q.first;
                CMD_C2_RD: acc_q <= ctl_q.second;
                CMD_C3_RD: acc_q <= ctl_q.third;
                CMD_C4_RD: acc_q <= ctl_q.fourth;
                CMD_PRE_RD: begin
                    b_q   <= tm_q.pre_cnt[BYTE_W-1:NIB_W];
                    acc_q <= tm_q.pre_cnt[NIB_W-1:0];
                end
                CMD_T1_RD: begin
                    b_q   <= tm_q.t1_cnt[BYTE_W-1:NIB_W];
                    acc_q <= tm_q.t1_cnt[NIB_W-1:0];
                end
                CMD_T2_RD: begin
                    b_q   <= tm_q.t2_cnt[BYTE_W-1:NIB_W];
                    acc_q <= tm_q.t2_cnt[NIB_W-1:0];
                end
                default: ;
            endcase
        end
    end

    // ****************************************************************
    // Timer control registers
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            ctl_q <= '0;
        end else if (cmd_fire) begin
            unique case (cmd)
                CMD_MODE_WR: ctl_q.mode   <= acc_q;
                CMD_C1_WR:   ctl_q.first  <= acc_q;
                CMD_C2_WR:   ctl_q.second <= acc_q;
                CMD_C3_WR:   ctl_q.third  <= acc_q;
                CMD_C4_WR:   ctl_q.fourth <= acc_q;
                default: ;
            endcase
        end
    end

    // ****************************************************************
    // Timer counts and reloads
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            tm_q <= '0;
        end else if (cmd_fire) begin
            unique case (cmd)
                CMD_PRE_WR: begin
                    tm_q.pre_cnt <= trx_join(b_q, acc_q);
                    tm_q.pre_rld <= trx_join(b_q, acc_q);
                end
                CMD_T1_WR: begin
                    tm_q.t1_cnt <= trx_join(b_q, acc_q);
                    tm_q.t1_rld <= trx_join(b_q, acc_q);
                end
                CMD_T2_WR: begin
                    tm_q.t2_cnt <= trx_join(b_q, acc_q);
                    tm_q.t2_rl  <= trx_join(b_q, acc_q);
                end
                CMD_T2H_WR:  tm_q.t2_rh  <= trx_join(b_q, acc_q);
                CMD_T1R_WR:  tm_q.t1_rld <= trx_join(b_q, acc_q);
                CMD_T2_LOAD: tm_q.t2_cnt <= tm_q.t2_rl;
                CMD_DISP_WR: begin
                    tm_q.disp_cnt <= acc_q;
                    tm_q.disp_rld <= acc_q;
                end
                default: ;
            endcase
        end
    end

    // ****************************************************************
    // Interrupt control and request flags
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            intc1_q <= RST_NIB;
            intc2_q <= RST_NIB;
        end else if (wr_en && awaddr_q == OFF_INTC) begin
            intc1_q <= wdata_q[NIB_W-1:0];
            intc2_q <= wdata_q[BYTE_W-1:NIB_W];
        end
    end

    assign en_bits  = {intc2_q[EN3_BIT], intc1_q[EN2_BIT], intc1_q[EN1_BIT]};
    assign tst_sel  = {cmd_fire && cmd == CMD_TST3,
                       cmd_fire && cmd == CMD_TST2,
                       cmd_fire && cmd == CMD_TST1};
    assign flag_clr = tst_sel & ~en_bits & flag_q;
    assign set_all  = flag_set
                    | ({NFLAG{wr_en && awaddr_q == OFF_FSET}} & wdata_q[NFLAG-1:0]);

    // A set in the clearing cycle wins
    always_ff @(posedge clk) begin
        if (rst) begin
            flag_q <= '0;
        end else begin
            flag_q <= (flag_q & ~flag_clr) | set_all;
        end
    end

    // Skip result of the last executed command
    always_ff @(posedge clk) begin
        if (rst) begin
            skip_q <= 1'b0;
        end else if (cmd_fire) begin
            skip_q <= |flag_clr;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign s_axi_awready = awready_q;
    assign s_axi_wready  = wready_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;
    assign ctrl          = ctl_q;
    assign skip_next     = skip_q;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    chk_mode_load: assert property (
        cmd_fire && cmd == CMD_MODE_WR |=> ctl_q.mode == $past(acc_q))
        else $error("mode select not loaded from accumulator");
    chk_first_read: assert property (
        cmd_fire && cmd == CMD_C1_RD |=> acc_q == $past(ctl_q.first))
        else $error("first control not read into accumulator");
    chk_third_write: assert property (
        cmd_fire && cmd == CMD_C3_WR |=> ctl_q.third == $past(acc_q) && $stable(ctl_q.first))
        else $error("third control write wrong");
    chk_pre_read: assert property (
        cmd_fire && cmd == CMD_PRE_RD
        |=> {b_q, acc_q} == $past(tm_q.pre_cnt) && $stable(tm_q.pre_cnt))
        else $error("prescaler read wrong or count disturbed");
    chk_pre_write: assert property (
        cmd_fire && cmd == CMD_PRE_WR
        |=> tm_q.pre_cnt == {$past(b_q), $past(acc_q)} && tm_q.pre_rld == tm_q.pre_cnt)
        else $error("prescaler write wrong");
    chk_t1_rld_only: assert property (
        cmd_fire && cmd == CMD_T1R_WR
        |=> tm_q.t1_rld == {$past(b_q), $past(acc_q)} && $stable(tm_q.t1_cnt))
        else $error("timer one reload-only write wrong");
    chk_t2h_only: assert property (
        cmd_fire && cmd == CMD_T2H_WR
        |=> tm_q.t2_rh == {$past(b_q), $past(acc_q)} && $stable(tm_q.t2_cnt))
        else $error("timer two high reload write wrong");
    chk_t2_load: assert property (
        cmd_fire && cmd == CMD_T2_LOAD |=> tm_q.t2_cnt == $past(tm_q.t2_rl))
        else $error("timer two not loaded from low reload");
    chk_disp_write: assert property (
        cmd_fire && cmd == CMD_DISP_WR
        |=> tm_q.disp_cnt == $past(acc_q) && tm_q.disp_rld == $past(acc_q))
        else $error("display timer write wrong");
    chk_tst1_skip: assert property (
        cmd_fire && cmd == CMD_TST1 && !intc1_q[EN1_BIT] && flag_q[0] && !flag_set[0]
        |=> skip_q && !flag_q[0])
        else $error("timer one test did not clear and skip");
    chk_tst2_nop: assert property (
        cmd_fire && cmd == CMD_TST2 && intc1_q[EN2_BIT]
        |=> !skip_q && flag_q[1] == ($past(flag_q[1]) | $past(flag_set[1])))
        else $error("timer two test not a no-operation when enabled");
    chk_tst3_skip: assert property (
        cmd_fire && cmd == CMD_TST3 && !intc2_q[EN3_BIT]
        |=> skip_q == $past(flag_q[2]))
        else $error("timer three test skip wrong");
    chk_first_write: assert property (
        cmd_fire && cmd == CMD_C1_WR |=> ctl_q.first == $past(acc_q))
        else $error("first control not written from accumulator");
    chk_second_read: assert property (
        cmd_fire && cmd == CMD_C2_RD |=> acc_q == $past(ctl_q.second))
        else $error("second control not read into accumulator");
    chk_second_write: assert property (
        cmd_fire && cmd == CMD_C2_WR |=> ctl_q.second == $past(acc_q))
        else $error("second control not written from accumulator");
    chk_third_read: assert property (
        cmd_fire && cmd == CMD_C3_RD |=> acc_q == $past(ctl_q.third))
        else $error("third control not read into accumulator");
    chk_fourth_read: assert property (
        cmd_fire && cmd == CMD_C4_RD |=> acc_q == $past(ctl_q.fourth))
        else $error("fourth control not read into accumulator");
    chk_fourth_write: assert property (
        cmd_fire && cmd == CMD_C4_WR |=> ctl_q.fourth == $past(acc_q))
        else $error("fourth control not written from accumulator");
    chk_t1_read: assert property (
        cmd_fire && cmd == CMD_T1_RD |=> {b_q, acc_q} == $past(tm_q.t1_cnt))
        else $error("timer one read wrong");
    chk_t1_write: assert property (
        cmd_fire && cmd == CMD_T1_WR
        |=> tm_q.t1_cnt == {$past(b_q), $past(acc_q)} && tm_q.t1_rld == tm_q.t1_cnt)
        else $error("timer one write wrong");
    chk_t2_read: assert property (
        cmd_fire && cmd == CMD_T2_RD |=> {b_q, acc_q} == $past(tm_q.t2_cnt))
        else $error("timer two read wrong");
    chk_t2_write: assert property (
        cmd_fire && cmd == CMD_T2_WR
        |=> tm_q.t2_cnt == {$past(b_q), $past(acc_q)} && tm_q.t2_rl == tm_q.t2_cnt)
        else $error("timer two write wrong");
    chk_tst1_nop: assert property (
        cmd_fire && cmd == CMD_TST1 && intc1_q[EN1_BIT] |=> !skip_q)
        else $error("timer one test not a no-operation when enabled");
    chk_tst2_skip: assert property (
        cmd_fire && cmd == CMD_TST2 && !intc1_q[EN2_BIT] |=> skip_q == $past(flag_q[1]))
        else $error("timer two test skip wrong");

endmodule

// ### bench/trx_flag_src.sv
// Model of the timer side that raises interrupt request flags.
// Assumes the bench calls pulse() from a process aligned to clk.
`timescale 1ns/10ps
module trx_flag_src
    import trx_pkg::*;
(
    // Clock
    input  wire logic             clk,
    // Flag set pulses
    output logic [NFLAG-1:0]      flag_set
);
    initial flag_set = 3'h0;

    // One-cycle set pulse for one timer flag
    task automatic pulse(input int t);
        @(posedge clk);
        flag_set <= 3'(1 << t);
        @(posedge clk);
        flag_set <= 3'h0;
    endtask
endmodule

// ### bench/tb_top.sv
// Self-checking bench for the timer register transfer block.
// Assumes the AXI4-Lite map and command codes of the package.
`timescale 1ns/10ps
module tb_top;
    import trx_pkg::*;
    logic            clk, rst, awvalid, wvalid, bready, arvalid, rready;
    logic            awready, wready, bvalid, arready, rvalid, skip_next;
    logic [7:0]      awaddr, araddr;
    logic [31:0]     wdata, rdata;
    logic [1:0]      bresp, rresp;
    logic [2:0]      flag_set;
    trx_ctrl_t       ctrl;
    int              error_cnt, tests_run, cyc;

    trx_timer_xfer dut (.clk(clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .flag_set(flag_set), .ctrl(ctrl), .skip_next(skip_next));
    trx_flag_src cpu (.clk(clk), .flag_set(flag_set));

    // ****************************************************************
    // Checks and bus tasks
    // ****************************************************************
    task automatic stop_test;
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        chk({30'h0, bresp}, {30'h0, er});
        bready <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        chk(rdata, e);
        chk({30'h0, rresp}, {30'h0, er});
        rready <= 1'b0;
        @(posedge clk);
    endtask

    // Loads accumulator and B, then executes one command
    task automatic cmd(input logic [4:0] c, input logic [3:0] a, input logic [3:0] b);
        wr(OFF_ACC, {28'h0, a}, RESP_OKAY);
        wr(OFF_BREG, {28'h0, b}, RESP_OKAY);
        wr(OFF_CMD, {27'h0, c}, RESP_OKAY);
    endtask

    // ****************************************************************
    // Clock, timeout and tests
    // ****************************************************************
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc++;
        if (cyc == 6000) begin
            error_cnt++;
            stop_test;
        end
    end

    initial begin
        {rst, awvalid, wvalid, bready, arvalid, rready} = 6'h20;
        {awaddr, araddr, wdata} = 48'h0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk({11'h0, skip_next, ctrl}, 32'h0);
        for (int k = 0; k < 5; k++) begin
            cmd(5'(2 * k + 1), 4'(k + 5), 4'h0);
            chk(32'(ctrl[4 * k +: 4]), 32'(k + 5));
        end
        rd(OFF_CTRL, 32'h98765, RESP_OKAY);
        for (int k = 1; k < 5; k++) begin
            cmd(5'(2 * k), 4'h0, 4'h0);
            rd(OFF_ACC, 32'(k + 5), RESP_OKAY);
        end
        $display("test control nibbles done");
        cmd(CMD_PRE_WR, 4'h3, 4'hc);
        rd(OFF_PRE, 32'hc3c3, RESP_OKAY);
        cmd(CMD_PRE_RD, 4'h0, 4'h0);
        rd(OFF_ACC, 32'h3, RESP_OKAY);
        rd(OFF_BREG, 32'hc, RESP_OKAY);
        rd(OFF_PRE, 32'hc3c3, RESP_OKAY);
        cmd(CMD_T1_WR, 4'ha, 4'h5);
        rd(OFF_T1, 32'h5a5a, RESP_OKAY);
        cmd(CMD_T1R_WR, 4'h1, 4'he);
        rd(OFF_T1, 32'he15a, RESP_OKAY);
        cmd(CMD_T1_RD, 4'h0, 4'h0);
        rd(OFF_ACC, 32'ha, RESP_OKAY);
        rd(OFF_BREG, 32'h5, RESP_OKAY);
        cmd(CMD_T2_WR, 4'hb, 4'h7);
        rd(OFF_T2, 32'h007b7b, RESP_OKAY);
        cmd(CMD_T2H_WR, 4'hd, 4'h2);
        rd(OFF_T2, 32'h2d7b7b, RESP_OKAY);
        cmd(CMD_T2_LOAD, 4'h0, 4'h0);
        rd(OFF_T2, 32'h2d7b7b, RESP_OKAY);
        cmd(CMD_T2_RD, 4'h0, 4'h0);
        rd(OFF_ACC, 32'hb, RESP_OKAY);
        rd(OFF_BREG, 32'h7, RESP_OKAY);
        cmd(CMD_DISP_WR, 4'h6, 4'h0);
        rd(OFF_DISP, 32'h66, RESP_OKAY);
        $display("test byte transfers done");
        for (int t = 0; t < 3; t++) begin
            cpu.pulse(t);
            wr(OFF_INTC, 32'h1 << (t + 2), RESP_OKAY);
            rd(OFF_INTC, 32'h1 << (t + 2), RESP_OKAY);
            cmd(5'(20 + t), 4'h0, 4'h0);
            rd(OFF_STAT, 32'h2 << t, RESP_OKAY);
            chk(32'(skip_next), 32'h0);
            wr(OFF_INTC, 32'h0, RESP_OKAY);
            cmd(5'(20 + t), 4'h0, 4'h0);
            rd(OFF_STAT, 32'h1, RESP_OKAY);
            chk(32'(skip_next), 32'h1);
            cmd(5'(20 + t), 4'h0, 4'h0);
            rd(OFF_STAT, 32'h0, RESP_OKAY);
        end
        $display("test flag skips done");
        wr(OFF_FSET, 32'h7, RESP_OKAY);
        rd(OFF_FSET, 32'h7, RESP_OKAY);
        cmd(CMD_TST1, 4'h0, 4'h0);
        rd(OFF_STAT, 32'hd, RESP_OKAY);
        cmd(CMD_NOP, 4'h0, 4'h0);
        rd(OFF_STAT, 32'hc, RESP_OKAY);
        $display("test flag register done");
        wr(8'h3c, 32'h1, RESP_SLVERR);
        rd(8'h3c, 32'h0, RESP_SLVERR);
        $display("test unmapped done");
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk({11'h0, skip_next, ctrl}, 32'h0);
        rd(OFF_T1, 32'h0, RESP_OKAY);
        $display("test mid-run reset done");
        stop_test;
    end
endmodule
